// ---- src/fpg_flash_guard.sv ----
// Notes on behaviour
// - programming only clears bits to zero
// - erase sets whole 512-byte page to FF
// - operations hardware timed, cpu stalled meanwhile
// - two key codes in order before operation
// - bad key or unkeyed attempt blocks until reset
// - key relocks after each firmware operation, not after debug operations
// - write-enable steers data writes into flash
// - erase-enable plus write erases addressed page
// - two-byte select picks single or pair programming
// - pair programmed on odd address write only
// - data reads always go to xram
// - lock byte complement counts locked pages
// - lock byte page locked whenever any locked
// - debug port denied locked pages
// - lock byte always readable
// - lock byte bits never further cleared
// - device erase clears everything including lock byte
// - unlocked firmware denied locked pages, lock page
// - locked firmware reaches all, never erases lock page
module fpg_flash_guard
    import fpg_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input fpg_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // cpu data moves
    input fpg_xw_req_t xw_req,
    input wire logic xr_valid,
    input wire logic [15:0] xr_addr,
    output logic xram_wr,
    output logic xram_rd,
    output logic [15:0] xram_addr,
    output logic [7:0] xram_wdata,
    // cpu code reads
    input wire logic cr_valid,
    input wire logic [15:0] cr_addr,
    input wire logic [15:0] exec_addr,
    output logic [7:0] code_rdata,
    output logic code_rvalid,
    // debug port
    input fpg_dbg_req_t dbg_req,
    output logic dbg_ready,
    output logic [7:0] dbg_rdata,
    output logic dbg_done,
    output logic dbg_denied,
    // system
    output logic cpu_stall,
    output logic flash_error_reset
);
    localparam logic [19:0] PROG_LOAD = 20'(PROG_CYC - 1);
    localparam logic [19:0] ERASE_LOAD = 20'(ERASE_CYCLES - 1);

    fpg_state_t s_r;
    fpg_state_t s_nxt;
    logic [7:0] flash_mem [ARRAY_BYTES];
    logic mem_we;
    logic [13:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] lock_byte;
    logic exec_locked;
    logic tgt_locked;
    logic fw_deny;
    logic fw_write;

    function automatic logic page_locked(input logic [4:0] pg, input logic [7:0] lb);
        logic [7:0] n_pages;
        n_pages = ~lb;
        page_locked = (n_pages != 8'h00) && ((pg == LOCK_PAGE) || ({3'h0, pg} < n_pages));
    endfunction : page_locked

    function automatic logic reserved(input logic [15:0] a);
        reserved = (a[15:14] != 2'h0);
    endfunction : reserved

    assign lock_byte = flash_mem[LOCK_ADDR];
    assign exec_locked = page_locked(exec_addr[13:9], lock_byte);

    always_comb begin
        s_nxt = s_r;
        s_nxt.reg_rdata = 8'h00;
        s_nxt.code_rvalid = 1'b0;
        s_nxt.dbg_done = 1'b0;
        s_nxt.dbg_denied = 1'b0;
        s_nxt.ferr = 1'b0;
        s_nxt.xram_wr = 1'b0;
        s_nxt.xram_rd = 1'b0;
        mem_we = 1'b0;
        mem_wa = s_r.paddr;
        mem_wd = ERASED_BYTE;
        fw_deny = 1'b0;
        fw_write = 1'b0;
        tgt_locked = 1'b0;

        if (reg_req.wr) begin
            unique case (reg_req.addr)
                ADDR_PROG_STORE_CTRL: begin
                    s_nxt.store_write_enable = reg_req.wdata[PSC_WRITE_EN_BIT];
                    s_nxt.page_erase_enable = reg_req.wdata[PSC_ERASE_EN_BIT];
                end
                ADDR_UNLOCK_KEY: begin
                    unique case (s_r.key)
                        KEY_LOCKED: s_nxt.key = (reg_req.wdata == KEY_FIRST) ? KEY_HALF : KEY_BLOCKED;
                        KEY_HALF: s_nxt.key = (reg_req.wdata == KEY_SECOND) ? KEY_ARMED : KEY_BLOCKED;
                        KEY_ARMED: s_nxt.key = KEY_BLOCKED;
                        KEY_BLOCKED: s_nxt.key = KEY_BLOCKED;
                    endcase
                end
                ADDR_PREFETCH_CTRL: s_nxt.bwe = reg_req.wdata[PFC_TWO_BYTE_BIT];
                ADDR_SCALING_CTRL: s_nxt.slow_read_timing = reg_req.wdata[FSC_SLOW_READ_BIT];
                default: ;
            endcase
        end
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_PROG_STORE_CTRL: s_nxt.reg_rdata = {6'h00, s_r.page_erase_enable, s_r.store_write_enable};
                ADDR_UNLOCK_KEY: s_nxt.reg_rdata = {6'h00, s_r.key};
                ADDR_PREFETCH_CTRL: s_nxt.reg_rdata = {7'h00, s_r.bwe};
                ADDR_SCALING_CTRL: s_nxt.reg_rdata = 8'(s_r.slow_read_timing) << FSC_SLOW_READ_BIT;
                ADDR_STATUS: begin
                    s_nxt.reg_rdata[STAT_BUSY_BIT] = (s_r.st != OP_IDLE);
                    s_nxt.reg_rdata[STAT_BLOCKED_BIT] = (s_r.key == KEY_BLOCKED);
                    s_nxt.reg_rdata[STAT_EVEN_HELD_BIT] = s_r.ev_valid;
                end
                default: s_nxt.reg_rdata = 8'h00;
            endcase
        end

        // data reads never reach the array
        if (xr_valid) begin
            s_nxt.xram_rd = 1'b1;
            s_nxt.xram_addr = xr_addr;
        end

        unique case (s_r.st)
            OP_IDLE: begin
                if (xw_req.valid && !s_r.store_write_enable) begin
                    s_nxt.xram_wr = 1'b1;
                    s_nxt.xram_addr = xw_req.addr;
                    s_nxt.xram_wdata = xw_req.data;
                end else if (xw_req.valid) begin
                    fw_write = 1'b1;
                    tgt_locked = page_locked(xw_req.addr[13:9], lock_byte);
                    if (s_r.page_erase_enable) begin
                        fw_deny = reserved(xw_req.addr) || (xw_req.addr[13:9] == LOCK_PAGE)
                            || (tgt_locked && !exec_locked);
                    end else begin
                        fw_deny = reserved(xw_req.addr) || (tgt_locked && !exec_locked)
                            || ((xw_req.addr[13:0] == LOCK_ADDR) && (lock_byte != ERASED_BYTE)
                            && ((xw_req.data & lock_byte) != lock_byte));
                    end
                    if (s_r.key != KEY_ARMED) begin
                        s_nxt.key = KEY_BLOCKED;
                    end else if (fw_deny) begin
                        s_nxt.ferr = 1'b1;
                    end else if (s_r.page_erase_enable) begin
                        s_nxt.st = OP_ERASE;
                        s_nxt.paddr = {xw_req.addr[13:9], 9'h000};
                        s_nxt.idx = 14'h0000;
                        s_nxt.walk_done = 1'b0;
                        s_nxt.cnt = ERASE_LOAD;
                        s_nxt.from_dbg = 1'b0;
                    end else if (s_r.bwe && !xw_req.addr[0]) begin
                        s_nxt.ev_valid = 1'b1;
                        s_nxt.ev_addr = xw_req.addr[13:0];
                        s_nxt.ev_data = xw_req.data;
                        s_nxt.key = KEY_LOCKED;
                    end else begin
                        s_nxt.st = OP_PROG;
                        s_nxt.cnt = PROG_LOAD;
                        s_nxt.idx = 14'h0000;
                        s_nxt.walk_done = 1'b0;
                        s_nxt.from_dbg = 1'b0;
                        s_nxt.ev_valid = 1'b0;
                        if (s_r.bwe) begin
                            s_nxt.paddr = {xw_req.addr[13:1], 1'b0};
                            s_nxt.pd0 = s_r.ev_data;
                            s_nxt.pd1 = xw_req.data;
                            s_nxt.pmask = {1'b1, s_r.ev_valid && (s_r.ev_addr == {xw_req.addr[13:1], 1'b0})};
                        end else begin
                            s_nxt.paddr = xw_req.addr[13:0];
                            s_nxt.pd0 = xw_req.data;
                            s_nxt.pmask = 2'b01;
                        end
                    end
                end else if (cr_valid) begin
                    tgt_locked = page_locked(cr_addr[13:9], lock_byte);
                    fw_deny = reserved(cr_addr)
                        || (tgt_locked && !exec_locked && (cr_addr[13:0] != LOCK_ADDR));
                    if (fw_deny) begin
                        s_nxt.ferr = 1'b1;
                    end else begin
                        s_nxt.code_rdata = flash_mem[cr_addr[13:0]];
                        s_nxt.code_rvalid = 1'b1;
                    end
                end else if (dbg_req.valid) begin
                    tgt_locked = page_locked(dbg_req.addr[13:9], lock_byte);
                    s_nxt.from_dbg = 1'b1;
                    s_nxt.idx = 14'h0000;
                    s_nxt.walk_done = 1'b0;
                    unique case (dbg_req.op)
                        DBG_READ: begin
                            if (reserved(dbg_req.addr)
                                || (tgt_locked && (dbg_req.addr[13:0] != LOCK_ADDR))) begin
                                s_nxt.dbg_denied = 1'b1;
                            end else begin
                                s_nxt.dbg_rdata = flash_mem[dbg_req.addr[13:0]];
                                s_nxt.dbg_done = 1'b1;
                            end
                        end
                        DBG_WRITE: begin
                            if (reserved(dbg_req.addr) || tgt_locked
                                // the first lock is allowed; once locked, the lock byte page is locked too, so every write to it is refused
                                || ((dbg_req.addr[13:0] == LOCK_ADDR) && (lock_byte != ERASED_BYTE)
                                && ((dbg_req.data & lock_byte) != lock_byte))) begin
                                s_nxt.dbg_denied = 1'b1;
                            end else begin
                                s_nxt.st = OP_PROG;
                                s_nxt.cnt = PROG_LOAD;
                                s_nxt.paddr = dbg_req.addr[13:0];
                                s_nxt.pd0 = dbg_req.data;
                                s_nxt.pmask = 2'b01;
                            end
                        end
                        DBG_ERASE: begin
                            if (reserved(dbg_req.addr) || tgt_locked) begin
                                s_nxt.dbg_denied = 1'b1;
                            end else begin
                                s_nxt.st = OP_ERASE;
                                s_nxt.cnt = ERASE_LOAD;
                                s_nxt.paddr = {dbg_req.addr[13:9], 9'h000};
                            end
                        end
                        DBG_DEV_ERASE: begin
                            s_nxt.st = OP_CHIP;
                            s_nxt.cnt = ERASE_LOAD;
                            s_nxt.paddr = 14'h0000;
                        end
                    endcase
                end
            end
            OP_PROG: begin
                if (!s_r.walk_done) begin
                    mem_wa = {s_r.paddr[13:1], s_r.idx[0] | s_r.paddr[0]};
                    mem_wd = (s_r.idx[0] ? s_r.pd1 : s_r.pd0) & flash_mem[mem_wa];
                    mem_we = s_r.pmask[s_r.idx[0]];
                    s_nxt.idx = 14'h0001;
                    s_nxt.walk_done = s_r.idx[0];
                end
            end
            OP_ERASE, OP_CHIP: begin
                if (!s_r.walk_done) begin
                    mem_wa = (s_r.st == OP_CHIP) ? s_r.idx : {s_r.paddr[13:9], s_r.idx[8:0]};
                    mem_wd = ERASED_BYTE;
                    mem_we = 1'b1;
                    s_nxt.idx = s_r.idx + 14'h0001;
                    s_nxt.walk_done = (s_r.st == OP_CHIP) ? (s_r.idx == ARRAY_LAST) : (s_r.idx[8:0] == PAGE_LAST);
                end
            end
        endcase

        if (s_r.st != OP_IDLE) begin
            if (s_r.cnt != 20'h00000) begin
                s_nxt.cnt = s_r.cnt - 20'h00001;
            end else if (s_r.walk_done || mem_we && s_nxt.walk_done) begin
                s_nxt.st = OP_IDLE;
                s_nxt.dbg_done = s_r.from_dbg;
                if (!s_r.from_dbg) begin
                    s_nxt.key = (s_r.key == KEY_BLOCKED) ? KEY_BLOCKED : KEY_LOCKED;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // flash cells are non-volatile, so reset leaves them alone
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            flash_mem[mem_wa] <= mem_wd;
        end
    end

    assign reg_rdata = s_r.reg_rdata;
    assign xram_wr = s_r.xram_wr;
    assign xram_rd = s_r.xram_rd;
    assign xram_addr = s_r.xram_addr;
    assign xram_wdata = s_r.xram_wdata;
    assign code_rdata = s_r.code_rdata;
    assign code_rvalid = s_r.code_rvalid;
    assign dbg_ready = (s_r.st == OP_IDLE);
    assign dbg_rdata = s_r.dbg_rdata;
    assign dbg_done = s_r.dbg_done;
    assign dbg_denied = s_r.dbg_denied;
    assign cpu_stall = (s_r.st != OP_IDLE);
    assign flash_error_reset = s_r.ferr;

    // checks
    logic [19:0] busy_len;
    always_ff @(posedge ref_clk) begin
        if (!reset_n || s_r.st == OP_IDLE) begin
            busy_len <= 20'h00000;
        end else begin
            busy_len <= busy_len + 20'h00001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_block_sticks: assert property (s_r.key == KEY_BLOCKED |=> s_r.key == KEY_BLOCKED)
        else $error("blocked key state left");
    a_unkeyed_blocks: assert property (fw_write && s_r.key != KEY_ARMED
        |=> s_r.key == KEY_BLOCKED && s_r.st == OP_IDLE)
        else $error("unkeyed flash write not blocked");
    a_key_before_op: assert property (s_r.st == OP_IDLE ##1 s_r.st != OP_IDLE && !s_r.from_dbg
        |-> $past(s_r.key) == KEY_ARMED)
        else $error("flash op started without armed key");
    a_relock_after: assert property ($fell(cpu_stall) && !s_r.dbg_done |-> s_r.key != KEY_ARMED)
        else $error("key still armed after operation");
    a_prog_length: assert property (s_r.st == OP_PROG ##1 s_r.st == OP_IDLE
        |-> $past(busy_len) == 20'(PROG_CYC - 1))
        else $error("program time wrong");
    a_steer_xram: assert property (s_r.st == OP_IDLE && xw_req.valid |=> xram_wr == !$past(s_r.store_write_enable))
        else $error("data write steered wrongly");
    a_erase_ones: assert property (mem_we && s_r.st != OP_PROG |-> mem_wd == ERASED_BYTE)
        else $error("erase wrote non-erased value");
    a_prog_clears: assert property (mem_we && s_r.st == OP_PROG |-> (mem_wd & ~flash_mem[mem_wa]) == 8'h00)
        else $error("program set a bit to one");
    a_read_xram: assert property (xr_valid |=> xram_rd && xram_addr == $past(xr_addr))
        else $error("data read not sent to xram");
    a_even_waits: assert property (fw_write && s_r.key == KEY_ARMED && !fw_deny && s_r.bwe && !s_r.page_erase_enable
        && !xw_req.addr[0] |=> s_r.st == OP_IDLE && s_r.ev_valid)
        else $error("even byte programmed alone");
    a_deny_reset: assert property (fw_deny && s_r.key == KEY_ARMED
        |=> flash_error_reset && s_r.st == OP_IDLE)
        else $error("forbidden access not reported");
    a_lock_page_safe: assert property (s_r.st == OP_ERASE && !s_r.from_dbg
        |-> s_r.paddr[13:9] != LOCK_PAGE)
        else $error("firmware erased lock byte page");

    c_page_erase: cover property (s_r.st == OP_ERASE ##1 s_r.st == OP_IDLE);
    c_pair_prog: cover property (s_r.st == OP_PROG && s_r.pmask == 2'b11);
    c_dev_erase: cover property (s_r.st == OP_CHIP ##1 s_r.st == OP_IDLE);
    c_blocked: cover property ($rose(s_r.key == KEY_BLOCKED));
endmodule : fpg_flash_guard

// ---- src/fpg_pkg.sv ----
package fpg_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned PROG_TIME_NS = 20000;
    localparam int unsigned ERASE_TIME_NS = 20000000;
    localparam int unsigned PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ERASE_CYC_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // array geometry
    localparam int unsigned ARRAY_BYTES = 16384;
    localparam logic [4:0] LOCK_PAGE = 5'h1F;
    localparam logic [13:0] LOCK_ADDR = 14'h3FFF;
    localparam logic [8:0] PAGE_LAST = 9'h1FF;
    localparam logic [13:0] ARRAY_LAST = 14'h3FFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // unlock codes
    localparam logic [7:0] KEY_FIRST = 8'hA5;
    localparam logic [7:0] KEY_SECOND = 8'hF1;

    // register offsets
    localparam logic [7:0] ADDR_PROG_STORE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h01;
    localparam logic [7:0] ADDR_PREFETCH_CTRL = 8'h02;
    localparam logic [7:0] ADDR_SCALING_CTRL = 8'h03;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // field positions
    localparam int unsigned PSC_WRITE_EN_BIT = 0;
    localparam int unsigned PSC_ERASE_EN_BIT = 1;
    localparam int unsigned PFC_TWO_BYTE_BIT = 0;
    localparam int unsigned FSC_SLOW_READ_BIT = 4;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_BLOCKED_BIT = 1;
    localparam int unsigned STAT_EVEN_HELD_BIT = 2;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_PROG = 2'b01,
        OP_ERASE = 2'b10,
        OP_CHIP = 2'b11
    } fpg_op_t;

    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF = 2'b01,
        KEY_ARMED = 2'b10,
        KEY_BLOCKED = 2'b11
    } fpg_key_t;

    typedef enum logic [1:0] {
        DBG_READ = 2'b00,
        DBG_WRITE = 2'b01,
        DBG_ERASE = 2'b10,
        DBG_DEV_ERASE = 2'b11
    } fpg_dbg_op_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fpg_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } fpg_xw_req_t;

    typedef struct packed {
        logic valid;
        fpg_dbg_op_t op;
        logic [15:0] addr;
        logic [7:0] data;
    } fpg_dbg_req_t;

    typedef struct packed {
        fpg_op_t st;
        fpg_key_t key;
        logic store_write_enable;
        logic page_erase_enable;
        logic bwe;
        logic slow_read_timing;
        logic [19:0] cnt;
        logic [13:0] idx;
        logic walk_done;
        logic [13:0] paddr;
        logic [7:0] pd0;
        logic [7:0] pd1;
        logic [1:0] pmask;
        logic from_dbg;
        logic ev_valid;
        logic [13:0] ev_addr;
        logic [7:0] ev_data;
        logic [7:0] reg_rdata;
        logic [7:0] code_rdata;
        logic code_rvalid;
        logic [7:0] dbg_rdata;
        logic dbg_done;
        logic dbg_denied;
        logic ferr;
        logic xram_wr;
        logic xram_rd;
        logic [15:0] xram_addr;
        logic [7:0] xram_wdata;
    } fpg_state_t;

    localparam fpg_state_t STATE_RESET = '0;
endpackage : fpg_pkg

// ---- tb/fpg_flash_guard_tb_top.sv ----
module fpg_flash_guard_tb_top;
    import fpg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned ERASE_SIM = 600;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    fpg_reg_req_t reg_req = '0;
    fpg_xw_req_t xw_req = '0;
    fpg_dbg_req_t dbg_req = '0;
    logic xr_valid = 1'b0;
    logic [15:0] xr_addr = 16'h0000;
    logic cr_valid = 1'b0;
    logic [15:0] cr_addr = 16'h0000;
    logic [15:0] exec_addr = 16'h3000;
    logic [7:0] reg_rdata, xram_wdata, code_rdata, dbg_rdata, peek_data, rd_count;
    logic [15:0] xram_addr;
    logic xram_wr, xram_rd, code_rvalid, dbg_ready, dbg_done, dbg_denied, cpu_stall, flash_error_reset;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;

    always #20 ref_clk = ~ref_clk;

    fpg_flash_guard #(.ERASE_CYCLES(ERASE_SIM)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .xw_req(xw_req), .xr_valid(xr_valid), .xr_addr(xr_addr), .xram_wr(xram_wr),
        .xram_rd(xram_rd), .xram_addr(xram_addr), .xram_wdata(xram_wdata), .cr_valid(cr_valid), .cr_addr(cr_addr),
        .exec_addr(exec_addr), .code_rdata(code_rdata), .code_rvalid(code_rvalid), .dbg_req(dbg_req),
        .dbg_ready(dbg_ready), .dbg_rdata(dbg_rdata), .dbg_done(dbg_done), .dbg_denied(dbg_denied),
        .cpu_stall(cpu_stall), .flash_error_reset(flash_error_reset));

    fpg_xram_model i_xram (.ref_clk(ref_clk), .xram_wr(xram_wr), .xram_rd(xram_rd), .xram_addr(xram_addr),
        .xram_wdata(xram_wdata), .peek_data(peek_data), .rd_count(rd_count));

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk) reg_req <= '0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk) reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk) reg_req <= '0;
        #1 check(reg_rdata, exp);
    endtask : reg_rd

    task automatic unlock;
        reg_wr(ADDR_UNLOCK_KEY, KEY_FIRST);
        reg_wr(ADDR_UNLOCK_KEY, KEY_SECOND);
    endtask : unlock

    task automatic data_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk) xw_req <= '{valid: 1'b1, addr: a, data: d};
        @(posedge ref_clk) xw_req.valid <= 1'b0;
        #1;
    endtask : data_wr

    // counts the cycles of stall, bounded so a stuck stall cannot hang the run
    task automatic stall_len(input logic [31:0] exp);
        logic [31:0] n;
        n = 0;
        while (cpu_stall === 1'b1 && n < 20000) begin
            @(posedge ref_clk) #1 n++;
        end
        check(n, exp);
    endtask : stall_len

    task automatic code_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk) begin
            cr_valid <= 1'b1;
            cr_addr <= a;
        end
        @(posedge ref_clk) cr_valid <= 1'b0;
        #1 check({code_rvalid, code_rdata}, {1'b1, exp});
    endtask : code_rd

    task automatic dbg(input fpg_dbg_op_t op, input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk) dbg_req <= '{valid: 1'b1, op: op, addr: a, data: d};
        @(posedge ref_clk) dbg_req.valid <= 1'b0;
        #1;
    endtask : dbg

    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1 check({dbg_ready, cpu_stall}, 2'b10);
        dbg(DBG_DEV_ERASE, 16'h0000, 8'h00);
        stall_len(16384);
        check(dbg_done, 1'b1);
        reg_rd(ADDR_UNLOCK_KEY, 8'h00);
        reg_wr(ADDR_UNLOCK_KEY, KEY_FIRST);
        reg_rd(ADDR_UNLOCK_KEY, 8'h01);
        reg_wr(ADDR_UNLOCK_KEY, KEY_SECOND);
        reg_rd(ADDR_UNLOCK_KEY, 8'h02);
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h01);
        data_wr(16'h0100, 8'h5A);
        check(xram_wr, 1'b0);
        stall_len(PROG_CYC);
        reg_rd(ADDR_UNLOCK_KEY, 8'h00);
        reg_rd(ADDR_PROG_STORE_CTRL, 8'h01);
        code_rd(16'h0100, 8'h5A);
        unlock();
        data_wr(16'h0100, 8'hA5);
        stall_len(PROG_CYC);
        code_rd(16'h0100, 8'h00);
        unlock();
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h03);
        data_wr(16'h0123, 8'h00);
        stall_len(ERASE_SIM);
        code_rd(16'h0100, ERASED_BYTE);
        code_rd(16'h01FF, ERASED_BYTE);
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h01);
        reg_wr(ADDR_PREFETCH_CTRL, 8'h01);
        unlock();
        data_wr(16'h0200, 8'h12);
        check(cpu_stall, 1'b0);
        reg_rd(ADDR_STATUS, 8'h04);
        unlock();
        data_wr(16'h0201, 8'h34);
        stall_len(PROG_CYC);
        code_rd(16'h0200, 8'h12);
        code_rd(16'h0201, 8'h34);
        unlock();
        data_wr(16'h0202, ERASED_BYTE);
        unlock();
        data_wr(16'h0203, 8'h56);
        stall_len(PROG_CYC);
        code_rd(16'h0202, ERASED_BYTE);
        code_rd(16'h0203, 8'h56);
        reg_wr(ADDR_SCALING_CTRL, 8'h10);
        reg_rd(ADDR_SCALING_CTRL, 8'h10);
        code_rd(16'h3FFF, ERASED_BYTE);
        @(posedge ref_clk) begin
            xr_valid <= 1'b1;
            xr_addr <= 16'h0100;
        end
        @(posedge ref_clk) xr_valid <= 1'b0;
        #1 check({xram_rd, xram_addr}, {1'b1, 16'h0100});
        check(code_rvalid, 1'b0);
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h00);
        data_wr(16'h0377, 8'h77);
        check({xram_wr, xram_addr, xram_wdata, cpu_stall}, {1'b1, 16'h0377, 8'h77, 1'b0});
        @(posedge ref_clk) #1 check(peek_data, 8'h77);
        check(rd_count, 8'h01);
        dbg(DBG_READ, 16'h0200, 8'h00);
        check({dbg_done, dbg_rdata}, {1'b1, 8'h12});
        dbg(DBG_READ, 16'h3FFF, 8'h00);
        check({dbg_done, dbg_rdata}, {1'b1, ERASED_BYTE});
        dbg(DBG_READ, 16'h4000, 8'h00);
        check({dbg_denied, dbg_done}, 2'b10);
        @(posedge ref_clk) begin
            cr_valid <= 1'b1;
            cr_addr <= 16'h4000;
        end
        @(posedge ref_clk) cr_valid <= 1'b0;
        #1 check({flash_error_reset, code_rvalid}, 2'b10);
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h01);
        data_wr(16'h0400, 8'h00);
        check(cpu_stall, 1'b0);
        reg_rd(ADDR_UNLOCK_KEY, 8'h03);
        unlock();
        reg_rd(ADDR_UNLOCK_KEY, 8'h03);
        reg_rd(ADDR_STATUS, 8'h02);
        reg_rd(8'h3C, 8'h00);
        // lock two pages (plus the lock byte page) through the debug port
        dbg(DBG_WRITE, 16'h3FFF, 8'hFD);
        stall_len(PROG_CYC);
        check(dbg_done, 1'b1);
        dbg(DBG_READ, 16'h0200, 8'h00);
        check({dbg_denied, dbg_done}, 2'b10);
        dbg(DBG_READ, 16'h0400, 8'h00);
        check({dbg_done, dbg_rdata}, {1'b1, ERASED_BYTE});
        dbg(DBG_ERASE, 16'h3E00, 8'h00);
        check({dbg_denied, cpu_stall}, 2'b10);
        dbg(DBG_WRITE, 16'h3FFF, 8'hF0);
        check({dbg_denied, cpu_stall}, 2'b10);
        dbg(DBG_READ, 16'h3FFF, 8'h00);
        check({dbg_done, dbg_rdata}, {1'b1, 8'hFD});
        @(posedge ref_clk) begin
            cr_valid <= 1'b1;
            cr_addr <= 16'h0000;
        end
        @(posedge ref_clk) cr_valid <= 1'b0;
        #1 check({flash_error_reset, code_rvalid}, 2'b10);
        // mid-run reset clears the blocked key; flash contents survive
        @(posedge ref_clk) begin
            reset_n <= 1'b0;
            exec_addr <= 16'h0000;
        end
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        reg_rd(ADDR_UNLOCK_KEY, 8'h00);
        unlock();
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h01);
        data_wr(16'h0201, 8'h30);
        stall_len(PROG_CYC);
        code_rd(16'h0201, 8'h30);
        unlock();
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h03);
        data_wr(16'h3E00, 8'h00);
        check({flash_error_reset, cpu_stall}, 2'b10);
        reg_wr(ADDR_PROG_STORE_CTRL, 8'h01);
        data_wr(16'h3FFF, 8'hFC);
        check({flash_error_reset, cpu_stall}, 2'b10);
        code_rd(16'h3FFF, 8'hFD);
        tally_and_finish();
    end
endmodule : fpg_flash_guard_tb_top

// ---- tb/fpg_xram_model.sv ----
module fpg_xram_model (
    // clock
    input wire logic ref_clk,
    // forwarded data moves
    input wire logic xram_wr,
    input wire logic xram_rd,
    input wire logic [15:0] xram_addr,
    input wire logic [7:0] xram_wdata,
    // bench view
    output logic [7:0] peek_data,
    output logic [7:0] rd_count = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end
    // small xram: low address byte selects the cell
    always @(posedge ref_clk) begin
        if (xram_wr) begin
            mem[xram_addr[7:0]] <= xram_wdata;
        end
        if (xram_rd) begin
            rd_count <= rd_count + 8'h01;
        end
    end
    assign peek_data = mem[xram_addr[7:0]];
endmodule : fpg_xram_model
